/* File: hdl/ccclk_pkg.sv */
// Shared constants and types of the chip clock controller
package ccclk_pkg;

  // ----------------------------------------------------------------
  // Oscillator indices, also the source select encodings
  // ----------------------------------------------------------------
  localparam int OSC_COUNT = 5;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] OSC_FAST_XTAL = 3'h0;
  localparam logic [SEL_W-1:0] OSC_SLOW_XTAL = 3'h1;
  localparam logic [SEL_W-1:0] OSC_FAST_RC = 3'h2;
  localparam logic [SEL_W-1:0] OSC_SLOW_RC = 3'h3;
  localparam logic [SEL_W-1:0] OSC_MID_RC = 3'h4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SYSCLK_RST_SEL = OSC_FAST_RC;
  localparam logic [SEL_W-1:0] TICK_RST_SEL = OSC_SLOW_RC;

  // ----------------------------------------------------------------
  // Divider field layout
  // ----------------------------------------------------------------
  localparam int DIV_STAGES = 16;
  localparam int DIV_SEL_W = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAST_STOP_NS = 1000;
  localparam int SLOW_STOP_NS = 100000;
  localparam int FAST_STOP_CYC = FAST_STOP_NS / CLK_PERIOD_NS;
  localparam int SLOW_STOP_CYC = SLOW_STOP_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    CCCLK_RUN,
    CCCLK_POWERDOWN
  } ccclk_pwr_t;

endpackage : ccclk_pkg

/* File: hdl/ccclk_glitchless_mux.sv */
// Glitch-free clock source multiplexer on sampled oscillator levels
module ccclk_glitchless_mux #(
  parameter int N = 5,
  parameter int SW = 3,
  parameter logic [SW-1:0] RST_SEL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [N-1:0] src_in,
  input wire logic [SW-1:0] sel_in,
  output logic clk_out,
  output logic [SW-1:0] cur_sel_out
);

  logic switch_now;

  // Change only while old output and new source are both low
  assign switch_now = (sel_in != cur_sel_out) && (int'(sel_in) < N) &&
                      !clk_out && !src_in[sel_in];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_sel_out <= RST_SEL;
    end else if (switch_now) begin
      cur_sel_out <= sel_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_out <= 1'b0;
    end else if (switch_now) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= src_in[cur_sel_out];
    end
  end

endmodule // ccclk_glitchless_mux

/* File: hdl/ccclk_stop_detect.sv */
// Oscillator stop detector: no level change for LIMIT cycles
module ccclk_stop_detect #(
  parameter int LIMIT = 50,
  parameter int CW = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic osc_level_in,
  output logic stop_out
);

  logic [CW-1:0] quiet_cnt;
  logic last_level;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_level <= 1'b0;
    end else begin
      last_level <= osc_level_in;
    end
  end

  // Saturates at the limit so a dead crystal reports once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_cnt <= '0;
    end else if (!enable_in || (osc_level_in != last_level)) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt != CW'(LIMIT)) begin
      quiet_cnt <= quiet_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_out <= 1'b0;
    end else begin
      stop_out <= enable_in && (osc_level_in == last_level) &&
                  (quiet_cnt == CW'(LIMIT - 1));
    end
  end

endmodule // ccclk_stop_detect

/* File: hdl/ccclk_top.sv */
// Chip clock controller: source muxes, stop detect, power-down, divider
//
// Overview of operation
// - Power-down entered only when enable bit set and core executes wait-for-interrupt.
// - Stay in power-down until a wake-up interrupt arrives, then leave.
// - Power-down stops fast crystal, fast RC and mid RC oscillators.
// - System clock chosen from five oscillators by three-bit select field.
// - Each crystal stop detector has its own enable and interrupt enable.
// - Enabling fast crystal detector forces mid RC oscillator on outside power-down.
// - Enabling slow crystal detector forces slow RC oscillator on.
// - Fast crystal stop while it drives system clock fails over to mid RC.
// - Fast crystal stop sets fail flag; interrupt when its enable is set.
// - Tick external clock chosen from five sources by tick select field.
// - Slow oscillators run in power-down; mid RC only with display and touch.
// - Power-down keeps slow peripheral clocks, stops system and peripheral buses.
// - Sixteen chained halving stages, one routed to the output pin.
// - Output frequency is input divided by two to the power N+1.
// - Setting the divider enable starts the chained divider.
// - Clearing enable runs divider until output low, then holds low.
// - USB clock derived from the fast RC oscillator.
module ccclk_top #(
  parameter int SLOW_STOP_LIMIT = ccclk_pkg::SLOW_STOP_CYC,
  parameter int FAST_STOP_LIMIT = ccclk_pkg::FAST_STOP_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [ccclk_pkg::OSC_COUNT-1:0] OSC_LEVEL_IN,
  input wire logic POWERDOWN_ENABLE_BIT_IN,
  input wire logic WAIT_FOR_INTERRUPT_INSTRUCTION_IN,
  input wire logic WAKEUP_IRQ_IN,
  input wire logic [ccclk_pkg::SEL_W-1:0] SYSCLK_SOURCE_SELECT_IN,
  input wire logic [ccclk_pkg::SEL_W-1:0] TICK_CLOCK_SOURCE_SELECT_IN,
  input wire logic [ccclk_pkg::OSC_COUNT-1:0] OSC_ENABLE_REQ_IN,
  input wire logic FAST_XTAL_DETECT_EN_IN,
  input wire logic SLOW_XTAL_DETECT_EN_IN,
  input wire logic FAST_CRYSTAL_FAIL_IRQ_ENABLE_IN,
  input wire logic SLOW_CRYSTAL_FAIL_IRQ_ENABLE_IN,
  input wire logic FAST_FAIL_CLEAR_IN,
  input wire logic SLOW_FAIL_CLEAR_IN,
  input wire logic DISPLAY_FUNCTION_EN_IN,
  input wire logic TOUCH_KEY_FUNCTION_EN_IN,
  input wire logic DIVIDER_RUN_ENABLE_IN,
  input wire logic [ccclk_pkg::DIV_SEL_W-1:0] DIVIDER_FREQUENCY_SELECT_IN,
  output logic [ccclk_pkg::OSC_COUNT-1:0] OSC_ENABLE_OUT,
  output logic POWERDOWN_OUT,
  output logic SYSCLK_OUT,
  output logic [ccclk_pkg::SEL_W-1:0] SYSCLK_SOURCE_OUT,
  output logic TICK_EXTERNAL_CLOCK_OUT,
  output logic SYS_BUS_CLK_EN_OUT,
  output logic PERIPHERAL_BUS_CLOCK_A_EN_OUT,
  output logic PERIPHERAL_BUS_CLOCK_B_EN_OUT,
  output logic SLOW_PERIPH_CLK_EN_OUT,
  output logic FAST_CRYSTAL_FAIL_FLAG_OUT,
  output logic SLOW_CRYSTAL_FAIL_FLAG_OUT,
  output logic CLOCK_FAIL_IRQ_OUT,
  output logic DIVIDED_CLOCK_OUT_PIN_OUT,
  output logic USB_CLK_OUT
);
  import ccclk_pkg::*;

  // ----------------------------------------------------------------
  // Oscillator input synchronisers
  // ----------------------------------------------------------------
  logic [OSC_COUNT-1:0] osc_s1, osc_s2, osc_s3, osc_level;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_s1 <= '0;
      osc_s2 <= '0;
      osc_s3 <= '0;
    end else begin
      osc_s1 <= OSC_LEVEL_IN;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // A change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < OSC_COUNT; g++) begin : g_filt
      always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          osc_level[g] <= 1'b0;
        end else if (osc_s2[g] == osc_s3[g]) begin
          osc_level[g] <= osc_s3[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power-down sequencing
  // ----------------------------------------------------------------
  ccclk_pwr_t pwr_state, next_pwr_state;
  logic pd;

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      CCCLK_RUN: begin
        if (POWERDOWN_ENABLE_BIT_IN && WAIT_FOR_INTERRUPT_INSTRUCTION_IN) begin
          next_pwr_state = CCCLK_POWERDOWN;
        end
      end
      CCCLK_POWERDOWN: begin
        if (WAKEUP_IRQ_IN) begin
          next_pwr_state = CCCLK_RUN;
        end
      end
      default: next_pwr_state = CCCLK_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pwr_state <= CCCLK_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  assign pd = (pwr_state == CCCLK_POWERDOWN);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      POWERDOWN_OUT <= 1'b0;
      SYS_BUS_CLK_EN_OUT <= 1'b0;
      PERIPHERAL_BUS_CLOCK_A_EN_OUT <= 1'b0;
      PERIPHERAL_BUS_CLOCK_B_EN_OUT <= 1'b0;
      SLOW_PERIPH_CLK_EN_OUT <= 1'b0;
    end else begin
      POWERDOWN_OUT <= pd;
      SYS_BUS_CLK_EN_OUT <= !pd;
      PERIPHERAL_BUS_CLOCK_A_EN_OUT <= !pd;
      PERIPHERAL_BUS_CLOCK_B_EN_OUT <= !pd;
      SLOW_PERIPH_CLK_EN_OUT <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  logic [OSC_COUNT-1:0] next_osc_en;
  logic mid_keep;

  assign mid_keep = DISPLAY_FUNCTION_EN_IN && TOUCH_KEY_FUNCTION_EN_IN;

  always_comb begin
    next_osc_en = OSC_ENABLE_REQ_IN;
    next_osc_en[OSC_FAST_XTAL] = OSC_ENABLE_REQ_IN[OSC_FAST_XTAL] && !pd;
    next_osc_en[OSC_FAST_RC] = OSC_ENABLE_REQ_IN[OSC_FAST_RC] && !pd;
    next_osc_en[OSC_MID_RC] = (OSC_ENABLE_REQ_IN[OSC_MID_RC] || FAST_XTAL_DETECT_EN_IN) &&
                              (!pd || mid_keep);
    next_osc_en[OSC_SLOW_RC] = OSC_ENABLE_REQ_IN[OSC_SLOW_RC] || SLOW_XTAL_DETECT_EN_IN;
    next_osc_en[OSC_SLOW_XTAL] = OSC_ENABLE_REQ_IN[OSC_SLOW_XTAL];
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OSC_ENABLE_OUT <= '0;
    end else begin
      OSC_ENABLE_OUT <= next_osc_en;
    end
  end

  // ----------------------------------------------------------------
  // Crystal stop detectors
  // ----------------------------------------------------------------
  // Detectors idle while their crystal is off, so power-down or a
  // software re-enable never reads as a failure
  logic fast_det_on, slow_det_on, fast_stop, slow_stop;

  assign fast_det_on = FAST_XTAL_DETECT_EN_IN && OSC_ENABLE_OUT[OSC_FAST_XTAL];
  assign slow_det_on = SLOW_XTAL_DETECT_EN_IN && OSC_ENABLE_OUT[OSC_SLOW_XTAL];

  ccclk_stop_detect #(
    .LIMIT(FAST_STOP_LIMIT),
    .CW(16)
  ) u_fast_det (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .enable_in(fast_det_on),
    .osc_level_in(osc_level[OSC_FAST_XTAL]),
    .stop_out(fast_stop)
  );

  ccclk_stop_detect #(
    .LIMIT(SLOW_STOP_LIMIT),
    .CW(24)
  ) u_slow_det (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .enable_in(slow_det_on),
    .osc_level_in(osc_level[OSC_SLOW_XTAL]),
    .stop_out(slow_stop)
  );

  // Set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FAST_CRYSTAL_FAIL_FLAG_OUT <= 1'b0;
    end else if (fast_stop) begin
      FAST_CRYSTAL_FAIL_FLAG_OUT <= 1'b1;
    end else if (FAST_FAIL_CLEAR_IN) begin
      FAST_CRYSTAL_FAIL_FLAG_OUT <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SLOW_CRYSTAL_FAIL_FLAG_OUT <= 1'b0;
    end else if (slow_stop) begin
      SLOW_CRYSTAL_FAIL_FLAG_OUT <= 1'b1;
    end else if (SLOW_FAIL_CLEAR_IN) begin
      SLOW_CRYSTAL_FAIL_FLAG_OUT <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CLOCK_FAIL_IRQ_OUT <= 1'b0;
    end else begin
      CLOCK_FAIL_IRQ_OUT <= (FAST_CRYSTAL_FAIL_FLAG_OUT && FAST_CRYSTAL_FAIL_IRQ_ENABLE_IN) ||
                            (SLOW_CRYSTAL_FAIL_FLAG_OUT && SLOW_CRYSTAL_FAIL_IRQ_ENABLE_IN);
    end
  end

  // ----------------------------------------------------------------
  // System clock selection with failover
  // ----------------------------------------------------------------
  // Failover overrides software until the fast detector is disabled or the fail flag is cleared, which
  // software does only after the crystal reports stable again
  logic failover_hold;
  logic [SEL_W-1:0] sys_sel;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      failover_hold <= 1'b0;
    end else if (fast_stop && SYSCLK_SOURCE_OUT == OSC_FAST_XTAL) begin
      failover_hold <= 1'b1;
    end else if (!FAST_CRYSTAL_FAIL_FLAG_OUT || !FAST_XTAL_DETECT_EN_IN) begin
      failover_hold <= 1'b0;
    end
  end

  assign sys_sel = failover_hold ? OSC_MID_RC : SYSCLK_SOURCE_SELECT_IN;

  ccclk_glitchless_mux #(
    .N(OSC_COUNT),
    .SW(SEL_W),
    .RST_SEL(SYSCLK_RST_SEL)
  ) u_sys_mux (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .src_in(osc_level),
    .sel_in(sys_sel),
    .clk_out(SYSCLK_OUT),
    .cur_sel_out(SYSCLK_SOURCE_OUT)
  );

  ccclk_glitchless_mux #(
    .N(OSC_COUNT),
    .SW(SEL_W),
    .RST_SEL(TICK_RST_SEL)
  ) u_tick_mux (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .src_in(osc_level),
    .sel_in(TICK_CLOCK_SOURCE_SELECT_IN),
    .clk_out(TICK_EXTERNAL_CLOCK_OUT),
    .cur_sel_out()
  );

  // ----------------------------------------------------------------
  // USB clock
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      USB_CLK_OUT <= 1'b0;
    end else begin
      USB_CLK_OUT <= osc_level[OSC_FAST_RC] && OSC_ENABLE_OUT[OSC_FAST_RC];
    end
  end

  // ----------------------------------------------------------------
  // Power-of-two clock output divider
  // ----------------------------------------------------------------
  // Bit N of a ripple-free counter is the N-th halving stage; a select
  // change while running may shorten one period
  logic [DIV_STAGES-1:0] div_cnt;
  logic div_run, div_stop_now;

  assign div_stop_now = div_run && !DIVIDER_RUN_ENABLE_IN && !DIVIDED_CLOCK_OUT_PIN_OUT;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_run <= 1'b0;
    end else if (DIVIDER_RUN_ENABLE_IN) begin
      div_run <= 1'b1;
    end else if (div_stop_now) begin
      div_run <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_cnt <= '0;
    end else if (div_stop_now) begin
      div_cnt <= '0;
    end else if (div_run) begin
      div_cnt <= div_cnt + DIV_STAGES'(1);
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DIVIDED_CLOCK_OUT_PIN_OUT <= 1'b0;
    end else if (div_run && !div_stop_now) begin
      DIVIDED_CLOCK_OUT_PIN_OUT <= div_cnt[DIVIDER_FREQUENCY_SELECT_IN];
    end else begin
      DIVIDED_CLOCK_OUT_PIN_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PD_ENTRY: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $rose(pd) |-> $past(POWERDOWN_ENABLE_BIT_IN) && $past(WAIT_FOR_INTERRUPT_INSTRUCTION_IN))
    else $error("Power-down entered without enable and wait-for-interrupt");

  AST_PD_WAKE: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pd && WAKEUP_IRQ_IN |=> !pd ##1 !POWERDOWN_OUT)
    else $error("Wake-up did not leave power-down");

  AST_PD_OSC_OFF: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pd && !mid_keep |=> !OSC_ENABLE_OUT[OSC_FAST_XTAL] && !OSC_ENABLE_OUT[OSC_FAST_RC] &&
                        !OSC_ENABLE_OUT[OSC_MID_RC])
    else $error("Fast oscillators still enabled in power-down");

  AST_DET_MID_ON: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    FAST_XTAL_DETECT_EN_IN && !pd |=> OSC_ENABLE_OUT[OSC_MID_RC])
    else $error("Fast detector enabled but mid RC off");

  AST_DET_SLOWRC_ON: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    SLOW_XTAL_DETECT_EN_IN |=> OSC_ENABLE_OUT[OSC_SLOW_RC])
    else $error("Slow detector enabled but slow RC off");

  AST_FAILOVER: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    fast_stop && SYSCLK_SOURCE_OUT == OSC_FAST_XTAL |=> failover_hold ##[0:40]
    (SYSCLK_SOURCE_OUT == OSC_MID_RC || !failover_hold))
    else $error("System clock did not fail over to mid RC");

  AST_FAIL_FLAG: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    fast_stop |=> FAST_CRYSTAL_FAIL_FLAG_OUT ##1
    (CLOCK_FAIL_IRQ_OUT || !$past(FAST_CRYSTAL_FAIL_IRQ_ENABLE_IN)))
    else $error("Fast crystal stop lost or interrupt missing");

  AST_SLOW_RUN_PD: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pd && OSC_ENABLE_REQ_IN[OSC_SLOW_XTAL] |=> OSC_ENABLE_OUT[OSC_SLOW_XTAL])
    else $error("Slow crystal stopped in power-down");

  AST_BUS_GATED: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pd |=> !SYS_BUS_CLK_EN_OUT && !PERIPHERAL_BUS_CLOCK_A_EN_OUT &&
           !PERIPHERAL_BUS_CLOCK_B_EN_OUT && SLOW_PERIPH_CLK_EN_OUT)
    else $error("Bus clocks not gated in power-down");

  AST_DIV_HALF: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    DIVIDER_RUN_ENABLE_IN && DIVIDER_FREQUENCY_SELECT_IN == 4'h0 &&
    $stable(DIVIDER_FREQUENCY_SELECT_IN) && div_run && $past(div_run, 2) |->
    DIVIDED_CLOCK_OUT_PIN_OUT != $past(DIVIDED_CLOCK_OUT_PIN_OUT))
    else $error("Divide-by-two output did not toggle");

  AST_DIV_STOP_LOW: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !div_run && !DIVIDER_RUN_ENABLE_IN |=> !DIVIDED_CLOCK_OUT_PIN_OUT)
    else $error("Stopped divider output not low");

  AST_DIV_NO_RUNT: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $fell(DIVIDER_RUN_ENABLE_IN) && DIVIDED_CLOCK_OUT_PIN_OUT |=>
    DIVIDED_CLOCK_OUT_PIN_OUT || div_run)
    else $error("Divider high phase cut short");

  AST_SYS_GLITCH: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $changed(SYSCLK_SOURCE_OUT) |-> !SYSCLK_OUT && !$past(SYSCLK_OUT))
    else $error("System clock switched while high");

  AST_USB_SRC: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    USB_CLK_OUT |-> $past(osc_level[OSC_FAST_RC]))
    else $error("USB clock not from fast RC");

endmodule // ccclk_top

/* File: tb/ccclk_osc_model.sv */
// Behavioural oscillator bank that feeds the clock controller
module ccclk_osc_model (
  input wire logic clk_in,
  input wire logic [4:0] enable_in,
  input wire logic fast_stall_in,
  input wire logic slow_stall_in,
  output logic [4:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half periods in system cycles, kept slow enough to pass the sampling muxes
  localparam int HALF [5] = '{3, 9, 3, 7, 4};
  int cnt [5];
  initial level_out = 5'h00;
  always @(posedge clk_in) begin
    for (int i = 0; i < 5; i++) begin
      if (!enable_in[i]) begin
        // An unpowered oscillator output sits low
        level_out[i] <= 1'h0;
        cnt[i] <= 0;
      end else if (i < 2 && (i == 0 ? fast_stall_in : slow_stall_in) && !level_out[i]) begin
        // A stalled crystal parks low, as a dead one would
        cnt[i] <= 0;
      end else if (cnt[i] >= HALF[i] - 1) begin
        level_out[i] <= ~level_out[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule // ccclk_osc_model

/* File: tb/ccclk_top_bench.sv */
// Self-checking bench of the chip clock controller
module ccclk_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccclk_pkg::*;
  localparam int FAST_LIM = 8;
  localparam int CEILING = 20000;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic pd_en = 1'h0, wait_for_interrupt_instruction = 1'h0, wake = 1'h0, fast_stall = 1'h0, slow_stall = 1'h0;
  logic [2:0] sys_sel = OSC_FAST_RC;
  logic [2:0] tick_sel = OSC_SLOW_RC;
  logic [4:0] osc_req = 5'h1F;
  logic fast_det = 1'h0, slow_det = 1'h0, fast_ie = 1'h0, slow_ie = 1'h0;
  logic fast_clr = 1'h0, slow_clr = 1'h0, disp = 1'h0, touch = 1'h0, div_en = 1'h0;
  logic [3:0] div_n = 4'h0;
  logic [4:0] osc_level, osc_en;
  logic [2:0] sys_src;
  logic pd, sysclk, tick_clk, bus_en, pa_en, pb_en, slow_en;
  logic fast_flag, slow_flag, irq, div_out, usb;
  // Watched clocks: 0 tick, 1 USB, 2 system
  logic [2:0] mon;
  assign mon = {sysclk, usb, tick_clk};
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int div_sel_list [4] = '{0, 1, 4, 7};

  always #10 clk = ~clk;

  ccclk_osc_model osc (.clk_in(clk), .enable_in(osc_en), .fast_stall_in(fast_stall),
    .slow_stall_in(slow_stall), .level_out(osc_level));

  ccclk_top #(.SLOW_STOP_LIMIT(20), .FAST_STOP_LIMIT(FAST_LIM)) uut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .OSC_LEVEL_IN(osc_level),
    .POWERDOWN_ENABLE_BIT_IN(pd_en), .WAIT_FOR_INTERRUPT_INSTRUCTION_IN(wait_for_interrupt_instruction),
    .WAKEUP_IRQ_IN(wake), .SYSCLK_SOURCE_SELECT_IN(sys_sel),
    .TICK_CLOCK_SOURCE_SELECT_IN(tick_sel), .OSC_ENABLE_REQ_IN(osc_req),
    .FAST_XTAL_DETECT_EN_IN(fast_det), .SLOW_XTAL_DETECT_EN_IN(slow_det),
    .FAST_CRYSTAL_FAIL_IRQ_ENABLE_IN(fast_ie), .SLOW_CRYSTAL_FAIL_IRQ_ENABLE_IN(slow_ie),
    .FAST_FAIL_CLEAR_IN(fast_clr), .SLOW_FAIL_CLEAR_IN(slow_clr),
    .DISPLAY_FUNCTION_EN_IN(disp), .TOUCH_KEY_FUNCTION_EN_IN(touch),
    .DIVIDER_RUN_ENABLE_IN(div_en), .DIVIDER_FREQUENCY_SELECT_IN(div_n),
    .OSC_ENABLE_OUT(osc_en), .POWERDOWN_OUT(pd), .SYSCLK_OUT(sysclk),
    .SYSCLK_SOURCE_OUT(sys_src), .TICK_EXTERNAL_CLOCK_OUT(tick_clk),
    .SYS_BUS_CLK_EN_OUT(bus_en), .PERIPHERAL_BUS_CLOCK_A_EN_OUT(pa_en),
    .PERIPHERAL_BUS_CLOCK_B_EN_OUT(pb_en), .SLOW_PERIPH_CLK_EN_OUT(slow_en),
    .FAST_CRYSTAL_FAIL_FLAG_OUT(fast_flag), .SLOW_CRYSTAL_FAIL_FLAG_OUT(slow_flag),
    .CLOCK_FAIL_IRQ_OUT(irq), .DIVIDED_CLOCK_OUT_PIN_OUT(div_out), .USB_CLK_OUT(usb));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Outputs are sampled on the falling edge, clear of the launching edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Lets the new select reach the mux before the source is judged
  task automatic wait_src(input logic [2:0] v);
    cyc(2);
    for (int i = 0; i < 300 && sys_src !== v; i++) @(negedge clk);
  endtask

  task automatic edges(input int k, input int n, output int e);
    logic last;
    logic now;
    e = 0;
    last = mon[k];
    repeat (n) begin
      @(negedge clk);
      now = mon[k];
      e += int'(now !== last);
      last = now;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_powerdown(input logic keep_mid);
    @(posedge clk);
    wait_for_interrupt_instruction <= 1'h1;
    disp <= 1'h1;
    touch <= keep_mid;
    cyc(4);
    check(pd, 1'h0);
    @(posedge clk);
    pd_en <= 1'h1;
    @(posedge clk);
    wait_for_interrupt_instruction <= 1'h0;
    cyc(3);
    check({pd, bus_en, pa_en, pb_en, slow_en}, 5'h11);
    check({osc_en[4], osc_en[2], osc_en[0], osc_en[3], osc_en[1]}, {keep_mid, 4'h3});
    cyc(5);
    check(pd, 1'h1);
    @(posedge clk);
    wake <= 1'h1;
    @(posedge clk);
    wake <= 1'h0;
    pd_en <= 1'h0;
    cyc(3);
    check({pd, bus_en, pa_en, pb_en}, 4'h7);
  endtask

  task automatic test_select();
    int e;
    for (int s = 0; s < 6; s++) begin
      @(posedge clk);
      sys_sel <= 3'(s);
      tick_sel <= 3'(s);
      wait_src(s == 5 ? OSC_MID_RC : 3'(s));
      check(sys_src, s == 5 ? OSC_MID_RC : 3'(s));
    end
    edges(2, 40, e);
    check(16'(e > 2), 16'h1);
    edges(1'h1, 40, e);
    check(16'(e > 2), 16'h1);
    @(posedge clk);
    osc_req[2:1] <= 2'h0;
    tick_sel <= OSC_SLOW_XTAL;
    cyc(10);
    edges(1'h1, 40, e);
    check(16'(e), 16'h0);
    edges(1'h0, 40, e);
    check(16'(e), 16'h0);
    @(posedge clk);
    tick_sel <= OSC_SLOW_RC;
    cyc(10);
    edges(1'h0, 40, e);
    check(16'(e > 2), 16'h1);
  endtask

  task automatic test_divider(input int n);
    int gap;
    @(posedge clk);
    div_n <= 4'(n);
    div_en <= 1'h1;
    repeat (2) begin
      for (int i = 0; i < 600 && div_out !== 1'h0; i++) @(negedge clk);
      for (int i = 0; i < 600 && div_out !== 1'h1; i++) @(negedge clk);
    end
    gap = 0;
    while (div_out === 1'h1 && gap < 600) begin @(negedge clk); gap++; end
    while (div_out === 1'h0 && gap < 600) begin @(negedge clk); gap++; end
    check(16'(gap), 16'(2 ** (n + 1)));
    // Drop the enable early in a high phase: that phase must still run full length
    // The falling edge just seen high counts as the first cycle of the phase
    @(posedge clk);
    div_en <= 1'h0;
    gap = 1;
    cyc(1);
    while (div_out === 1'h1 && gap < 600) begin @(negedge clk); gap++; end
    check(16'(gap), 16'(2 ** n));
    gap = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (div_out !== 1'h0) gap++;
    end
    check(16'(gap), 16'h0);
  endtask

  task automatic test_fail();
    @(posedge clk);
    fast_det <= 1'h1;
    slow_det <= 1'h1;
    slow_ie <= 1'h1;
    osc_req[4:3] <= 2'h0;
    sys_sel <= OSC_FAST_XTAL;
    wait_src(OSC_FAST_XTAL);
    check({osc_en[4], osc_en[3], fast_flag, irq}, 4'hC);
    @(posedge clk);
    fast_stall <= 1'h1;
    for (int i = 0; i < FAST_LIM + 30 && fast_flag !== 1'h1; i++) @(negedge clk);
    cyc(2);
    check({fast_flag, irq}, 2'h2);
    @(posedge clk);
    fast_ie <= 1'h1;
    cyc(2);
    check(irq, 1'h1);
    wait_src(OSC_MID_RC);
    check(sys_src, OSC_MID_RC);
    // Software recovery: cycle the crystal, clear the flag, then the select applies again
    @(posedge clk);
    fast_stall <= 1'h0;
    osc_req[0] <= 1'h0;
    cyc(3);
    @(posedge clk);
    osc_req[0] <= 1'h1;
    cyc(20);
    @(posedge clk);
    fast_clr <= 1'h1;
    slow_clr <= 1'h1;
    @(posedge clk);
    fast_clr <= 1'h0;
    slow_clr <= 1'h0;
    cyc(3);
    check({fast_flag, irq}, 2'h0);
    wait_src(OSC_FAST_XTAL);
    check(sys_src, OSC_FAST_XTAL);
    // Slow crystal stop: own flag and interrupt enable, no failover
    @(posedge clk);
    fast_ie <= 1'h0;
    osc_req[1] <= 1'h1;
    cyc(30);
    @(posedge clk);
    slow_stall <= 1'h1;
    for (int i = 0; i < 80 && slow_flag !== 1'h1; i++) @(negedge clk);
    cyc(2);
    check({slow_flag, irq, sys_src}, {2'h3, OSC_FAST_XTAL});
    @(posedge clk);
    slow_ie <= 1'h0;
    cyc(3);
    check({slow_flag, irq}, 2'h2);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    cyc(4);
    check({sys_src, pd, bus_en, pa_en, pb_en, slow_en}, {OSC_FAST_RC, 5'h0F});
    test_powerdown(1'h1);
    test_powerdown(1'h0);
    test_select();
    foreach (div_sel_list[i]) test_divider(div_sel_list[i]);
    test_fail();
    conclude();
  end
endmodule // ccclk_top_bench
